// ### an_page_source.sv
// Model of the negotiation side: strobes one received link code word.
// Assumes the capture block's clock; words change just after an edge.
`timescale 1ns/10ps
module an_page_source (
  input wire logic clk,
  input wire logic arst_n,
  output logic basePageValid,
  output logic nextPageValid,
  output logic [partner_ability_pkg::PageWidth-1:0] rxPageWord
);
  import partner_ability_pkg::*;
  // Idle lines at time zero
  initial begin
    basePageValid = 1'b0;
    nextPageValid = 1'b0;
    rxPageWord = PageResetValue;
  end
  // One-cycle strobe; the word is inverted after, so a late sample shows up
  task send(input logic b, input logic n, input logic [PageWidth-1:0] w);
    @(posedge clk);
    basePageValid <= b;
    nextPageValid <= n;
    rxPageWord <= w;
    @(posedge clk);
    basePageValid <= 1'b0;
    nextPageValid <= 1'b0;
    rxPageWord <= ~w;
  endtask
endmodule

// ### axil_ro_slave.sv
// AXI4-Lite slave handshake shell: one write and one read at a time.
// Assumes a master that follows AXI4-Lite valid/ready rules.
`timescale 1ns/10ps
module axil_ro_slave (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic wvalid,
  output logic wready,
  output logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  output logic arready,
  output logic rvalid,
  input wire logic rready,
  output logic wrFire,
  output logic rdFire
);
  import partner_ability_pkg::*;

  logic awHave_d, awHave_q; // Write address taken
  logic wHave_d, wHave_q;   // Write data taken
  logic bvalid_d, bvalid_q; // Write response pending
  logic rvalid_d, rvalid_q; // Read response pending
  // Readies are registered so every bus output leaves a flop; each one
  // mirrors the free state of its slot, so no handshake timing changes
  logic awReady_d, awReady_q; // Write address slot free
  logic wReady_d, wReady_q;   // Write data slot free
  logic arReady_d, arReady_q; // Read slot free

  // Accept address and data in either order; respond once both held
  always_comb begin
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    bvalid_d = bvalid_q;
    rvalid_d = rvalid_q;
    wrFire = 1'b0;
    if (awvalid && awReady_q) begin
      awHave_d = 1'b1;
    end
    if (wvalid && wReady_q) begin
      wHave_d = 1'b1;
    end
    if (awHave_q && wHave_q && !bvalid_q) begin
      wrFire = 1'b1;
      bvalid_d = 1'b1;
      awHave_d = 1'b0;
      wHave_d = 1'b0;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    // Read address is taken only while no read data is pending
    rdFire = arvalid && arReady_q;
    if (rdFire) begin
      rvalid_d = 1'b1;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    // A slot is free when nothing is held in it and no answer is pending
    awReady_d = !awHave_d && !bvalid_d;
    wReady_d = !wHave_d && !bvalid_d;
    arReady_d = !rvalid_d;
  end

  // Handshake state registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      arReady_q <= 1'b1;
    end else begin
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awReady_q <= awReady_d;
      wReady_q <= wReady_d;
      arReady_q <= arReady_d;
    end
  end

  assign awready = awReady_q;
  assign wready = wReady_q;
  assign arready = arReady_q;
  assign bvalid = bvalid_q;
  assign rvalid = rvalid_q;
endmodule

// ### link_partner_ability_capture.sv
// Link partner ability capture: a read-only status register behind AXI4-Lite.
// Assumes the auto-negotiation state machine on the same clock strobes each
// received link code word; software only reads.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module link_partner_ability_capture (
  input wire logic clk,
  input wire logic arst_n,
  // Auto-negotiation side: one-cycle strobes with the received word
  input wire logic basePageValid,
  input wire logic nextPageValid,
  input wire logic [partner_ability_pkg::PageWidth-1:0] rxPageWord,
  // AXI4-Lite write address channel
  input wire logic [partner_ability_pkg::AddrWidth-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel
  input wire logic [partner_ability_pkg::DataWidth-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel
  input wire logic [partner_ability_pkg::AddrWidth-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel
  output logic [partner_ability_pkg::DataWidth-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import partner_ability_pkg::*;

  // Base page keeps bits 7:0 only; upper bits belong to another block
  localparam logic [PageWidth-1:0] BaseKeepMask = 16'h00FF;
  localparam logic [PageWidth-1:0] NextKeepMask = 16'hFFFF;

  logic [PageWidth-1:0] basePage; // Captured base page view
  logic [PageWidth-1:0] nextPage; // Captured next page view
  logic wrFire;                    // Write address and data both taken
  logic rdFire;                    // Read address taken this cycle
  logic [AddrWidth-1:0] awAddr_d, awAddr_q; // Held write address
  view_t view_d, view_q;           // Which page was last received
  logic updated_d, updated_q;      // A page arrived since last status read
  logic [DataWidth-1:0] rdata_d, rdata_q; // Read data register
  logic [1:0] rresp_d, rresp_q;    // Read response register
  logic [1:0] bresp_d, bresp_q;    // Write response register

  // Is the address one of ours
  function automatic logic is_mapped(input logic [AddrWidth-1:0] addr);
    is_mapped = (addr == PartnerAbilityAddr) || (addr == CaptureStatusAddr);
  endfunction

  // Base page capture: bits 7, 6, 5 and selector 4:0
  page_capture #(
    .Width(PageWidth)
  ) u_base (
    .clk(clk),
    .arst_n(arst_n),
    .pageValid(basePageValid),
    .pageWord(rxPageWord),
    .keepMask(BaseKeepMask),
    .pageQ(basePage)
  );

  // Next page capture; only the negotiation strobe loads it, so the
  // acknowledge and all other fields are never touched by software
  page_capture #(
    .Width(PageWidth)
  ) u_next (
    .clk(clk),
    .arst_n(arst_n),
    .pageValid(nextPageValid),
    .pageWord(rxPageWord),
    .keepMask(NextKeepMask),
    .pageQ(nextPage)
  );

  // Bus handshakes
  axil_ro_slave u_bus (
    .clk(clk),
    .arst_n(arst_n),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wrFire(wrFire),
    .rdFire(rdFire)
  );

  // View select, update flag and response data
  always_comb begin
    view_d = view_q;
    updated_d = updated_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    bresp_d = bresp_q;
    awAddr_d = awAddr_q;
    // Latch the write address when it is taken
    if (s_axi_awvalid && s_axi_awready) begin
      awAddr_d = s_axi_awaddr;
    end
    // Last page received picks the view; if both strobe, next page wins
    if (nextPageValid) begin
      view_d = VIEW_NEXT;
    end else if (basePageValid) begin
      view_d = VIEW_BASE;
    end
    // Writes store nothing; mapped ones answer OKAY
    if (wrFire) begin
      bresp_d = is_mapped(awAddr_q) ? RespOkay : RespSlvErr;
    end
    if (rdFire) begin
      rdata_d = '0;
      rresp_d = RespOkay;
      if (s_axi_araddr == PartnerAbilityAddr) begin
        // One address, content picked by the last page
        rdata_d[PageWidth-1:0] = (view_q == VIEW_NEXT) ? nextPage : basePage;
      end else if (s_axi_araddr == CaptureStatusAddr) begin
        rdata_d[StatusViewBit] = view_q;
        rdata_d[StatusUpdatedBit] = updated_q;
      end else begin
        rresp_d = RespSlvErr; // Unmapped address reads zero with error
      end
    end
    // Update flag: a new page sets it and wins over the read that clears it
    if (rdFire && s_axi_araddr == CaptureStatusAddr) begin
      updated_d = 1'b0;
    end
    if (basePageValid || nextPageValid) begin
      updated_d = 1'b1;
    end
  end

  // Register the control state and responses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      view_q <= VIEW_BASE;
      updated_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RespOkay;
      bresp_q <= RespOkay;
      awAddr_q <= '0;
    end else begin
      view_q <= view_d;
      updated_q <= updated_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      bresp_q <= bresp_d;
      awAddr_q <= awAddr_d;
    end
  end

  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_bresp = bresp_q;
endmodule

// ### lpac_props.sv
// Checker for the partner ability capture block, watching its top ports.
// Assumes page strobes and AXI4-Lite share the clk and arst_n domain.
`timescale 1ns/10ps
module lpac_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic basePageValid,
  input wire logic nextPageValid,
  input wire logic [partner_ability_pkg::PageWidth-1:0] rxPageWord,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [partner_ability_pkg::AddrWidth-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [partner_ability_pkg::DataWidth-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import partner_ability_pkg::*;
  logic [15:0] expQ, expD; // Word the shared address should show
  view_t viewQ, viewD; // Kind of the last page
  logic arTake; // Read address taken
  logic quiet; // No page strobe this cycle
  // Last strobe wins; a next page beats a base page in the same cycle
  always_comb begin
    expD = basePageValid ? {8'h00, rxPageWord[7:0]} : expQ;
    viewD = basePageValid ? VIEW_BASE : viewQ;
    if (nextPageValid) begin
      expD = rxPageWord;
      viewD = VIEW_NEXT;
    end
  end
  // Expected state registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      expQ <= 16'h0000;
      viewQ <= VIEW_BASE;
    end else begin
      expQ <= expD;
      viewQ <= viewD;
    end
  end
  assign arTake = s_axi_arvalid && s_axi_arready;
  assign quiet = !basePageValid && !nextPageValid;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_page_read: assert property (arTake && quiet && s_axi_araddr == PartnerAbilityAddr
    |=> s_axi_rdata == {16'h0000, expQ}) else $error("shared register read mismatch");
  a_view_bit: assert property (arTake && quiet && s_axi_araddr == CaptureStatusAddr
    |=> s_axi_rdata[StatusViewBit] == viewQ) else $error("view bit mismatch");
  a_bad_addr: assert property (arTake && s_axi_araddr != PartnerAbilityAddr
    && s_axi_araddr != CaptureStatusAddr |=> s_axi_rresp == RespSlvErr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_good_addr: assert property (arTake && s_axi_araddr == PartnerAbilityAddr
    |=> s_axi_rresp == RespOkay) else $error("mapped read refused");
  a_read_due: assert property (arTake |=> s_axi_rvalid) else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data not held");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
endmodule
bind link_partner_ability_capture lpac_props i_lpac_props (.*);

// ### page_capture.sv
// Capture register for one received link code word view.
// Assumes pageValid is a one-cycle strobe from logic on the same clock.
`timescale 1ns/10ps
module page_capture #(
  parameter int Width = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pageValid,
  input wire logic [Width-1:0] pageWord,
  input wire logic [Width-1:0] keepMask,
  output logic [Width-1:0] pageQ
);
  import partner_ability_pkg::*;

  logic [Width-1:0] page_d; // Next captured value
  logic [Width-1:0] page_q; // Captured value

  // Only the state machine strobe loads; masked bits stay zero
  always_comb begin
    page_d = page_q;
    if (pageValid) begin
      page_d = pageWord & keepMask;
    end
  end

  // Register the captured word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= PageResetValue;
    end else begin
      page_q <= page_d;
    end
  end

  assign pageQ = page_q;
endmodule

// ### partner_ability_pkg.sv
// Package for the link partner ability capture block.
// Holds register offsets, field positions, reset values and bus constants.
package partner_ability_pkg;

  // Bus geometry
  localparam int AddrWidth = 8;
  localparam int DataWidth = 32;
  localparam int PageWidth = 16;

  // Register byte addresses (one aligned word each) and the printed register index
  localparam logic [AddrWidth-1:0] PartnerAbilityAddr = 8'h14;  // Index 0x05 times four
  localparam logic [AddrWidth-1:0] CaptureStatusAddr = 8'h40;   // View and update status
  localparam logic [AddrWidth-1:0] PartnerAbilityIndex = 8'h05; // Printed register index

  // Base page field positions
  localparam int TxCapBit = 7;
  localparam int TenFullDuplexCapBit = 6;
  localparam int TenHalfDuplexCapBit = 5;
  localparam int SelectorMsb = 4;
  localparam int SelectorLsb = 0;

  // Next page field positions
  localparam int MorePagesFlagBit = 15;
  localparam int AckBit = 14;
  localparam int PageTypeFlagBit = 13;
  localparam int ComplyAckFlagBit = 12;
  localparam int ToggleBit = 11;
  localparam int CodeMsb = 10;
  localparam int CodeLsb = 0;

  // Status register field positions
  localparam int StatusViewBit = 0;
  localparam int StatusUpdatedBit = 1;

  // Reset values
  localparam logic [PageWidth-1:0] PageResetValue = 16'h0000;

  // AXI4-Lite responses
  localparam logic [1:0] RespOkay = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;

  // Which page the register shows
  typedef enum logic {
    VIEW_BASE = 1'b0,
    VIEW_NEXT = 1'b1
  } view_t;

endpackage

// ### tb.sv
// Testbench: AXI4-Lite reads and writes against pages from the model.
// Assumes a 10 MHz clock and the capture block's package constants.
`timescale 1ns/10ps
module tb;
  import partner_ability_pkg::*;
  logic clk = 0, arst_n = 0;
  logic basePageValid, nextPageValid;
  logic [15:0] rxPageWord, e;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'hFFFFFFFF, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_mismatch = 0, n_compared = 0;
  // Base and next pages in turn; all-ones checks that base bits 15:8 drop
  logic [15:0] words [4] = '{16'hFFFF, 16'h2AAA, 16'h0041, 16'hD555};
  always #50 clk = ~clk;
  link_partner_ability_capture i_link_partner_ability_capture (.*);
  an_page_source i_an_page_source (.*);
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // A wait that ran out its bound ends the run
  task wt(input int i);
    if (i == 50) begin
      n_mismatch++;
      end_of_test;
    end
  endtask
  task wr(input logic [7:0] a, input logic [1:0] r, input logic [3:0] s = 4'hF);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    wt(i);
    s_axi_bready <= 0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  // A late read raises rready only once the answer stands, so the slave must hold it
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r, input bit late = 0);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= !late;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1;
    end
    wt(i);
    s_axi_rready <= 0;
    chk(s_axi_rdata, x);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1;
    rd(PartnerAbilityAddr, 32'h0, RespOkay);
    rd(CaptureStatusAddr, 32'h0, RespOkay);
    for (int k = 0; k < 4; k++) begin
      e = k[0] ? words[k] : {8'h00, words[k][7:0]};
      i_an_page_source.send(!k[0], k[0], words[k]);
      rd(PartnerAbilityAddr, {16'h0, e}, RespOkay);
      rd(CaptureStatusAddr, {30'h0, 1'b1, k[0]}, RespOkay);
      rd(CaptureStatusAddr, {31'h0, k[0]}, RespOkay);
    end
    // Low byte only: software keeps off the acknowledge bit
    wr(PartnerAbilityAddr, RespOkay, 4'h1);
    rd(PartnerAbilityAddr, 32'h0000D555, RespOkay, 1);
    wr(8'h80, RespSlvErr);
    rd(8'h80, 32'h0, RespSlvErr);
    i_an_page_source.send(1, 1, 16'h7F3C);
    rd(PartnerAbilityAddr, 32'h00007F3C, RespOkay);
    arst_n <= 0;
    @(posedge clk);
    arst_n <= 1;
    rd(PartnerAbilityAddr, 32'h0, RespOkay);
    end_of_test;
  end
endmodule
